// [core/serial_in_pkg.sv]
// constants shared by the stereo serial audio input port
// assumes nothing beyond a SystemVerilog elaborator
package serial_in_pkg;
    localparam int          MODE_W       = 2;
    localparam int          WLEN_W       = 2;
    localparam int          WORD_MAX     = 24;
    localparam int          POS_W        = 6;
    localparam int          FRAME_BCLKS  = 64;
    localparam int          HALF_BCLKS   = FRAME_BCLKS / 2;
    localparam int          I2S_DELAY    = 1;
    // framing modes
    localparam logic [1:0]  MODE_LJ      = 2'h0;
    localparam logic [1:0]  MODE_I2S     = 2'h1;
    localparam logic [1:0]  MODE_RJ      = 2'h2;
    localparam logic [1:0]  MODE_DSP     = 2'h3;
    // right-justified word length codes, control bits 1:0
    localparam logic [1:0]  WLEN_24      = 2'h0;
    localparam logic [1:0]  WLEN_20      = 2'h1;
    localparam logic [1:0]  WLEN_16      = 2'h2;
    localparam logic [5:0]  LEN_24       = 6'h18;
    localparam logic [5:0]  LEN_20       = 6'h14;
    localparam logic [5:0]  LEN_16       = 6'h10;
    // reset values of the control register
    localparam logic [1:0]  MODE_RESET   = MODE_LJ;
    localparam logic [1:0]  WLEN_RESET   = WLEN_24;
endpackage

// [core/level_sync.sv]
// two flip-flop synchroniser for slow levels
// assumes d_i changes rarely and is held for several clk_i periods
`timescale 1ns/1ps
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_meta = rst_i ? '0 : d_i;
        next_q    = rst_i ? '0 : meta;
    end

    always_ff @(posedge clk_i)
    begin
        meta <= next_meta;
        q_o  <= next_q;
    end
endmodule

// [core/pair_crossing.sv]
// carries a stereo sample pair from the bit clock domain to the core domain
// assumes load pulses are spaced far wider than a few core clock periods
`timescale 1ns/1ps
module pair_crossing #(
    parameter int W = 24
) (
    input  wire logic         link_clk_i,
    input  wire logic         link_rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] left_i,
    input  wire logic [W-1:0] right_i,
    input  wire logic         core_clk_i,
    input  wire logic         core_rst_i,
    output logic              valid_o,
    output logic      [W-1:0] left_o,
    output logic      [W-1:0] right_o
);
    logic [W-1:0] hold_l;
    logic [W-1:0] hold_r;
    logic         tog;
    logic [W-1:0] next_hold_l;
    logic [W-1:0] next_hold_r;
    logic         next_tog;
    logic         tog_sync;
    logic         seen;
    logic         next_seen;
    logic         next_valid;
    logic [W-1:0] next_left;
    logic [W-1:0] next_right;

    // link side: hold words and flip the toggle
    always_comb
    begin
        next_hold_l = load_i ? left_i : hold_l;
        next_hold_r = load_i ? right_i : hold_r;
        next_tog    = tog ^ load_i;
        if (link_rst_i)
        begin
            next_hold_l = '0;
            next_hold_r = '0;
            next_tog    = 1'b0;
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        hold_l <= next_hold_l;
        hold_r <= next_hold_r;
        tog    <= next_tog;
    end

    level_sync #(.W(1)) u_tog_sync (
        .clk_i (core_clk_i),
        .rst_i (core_rst_i),
        .d_i   (tog),
        .q_o   (tog_sync)
    );

    // core side: one pulse per toggle, words taken while stable
    always_comb
    begin
        next_seen  = tog_sync;
        next_valid = tog_sync ^ seen;
        next_left  = (tog_sync ^ seen) ? hold_l : left_o;
        next_right = (tog_sync ^ seen) ? hold_r : right_o;
        if (core_rst_i)
        begin
            next_seen  = 1'b0;
            next_valid = 1'b0;
            next_left  = '0;
            next_right = '0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        seen    <= next_seen;
        valid_o <= next_valid;
        left_o  <= next_left;
        right_o <= next_right;
    end
endmodule

// [core/serial_audio_in.sv]
// stereo serial audio input port: framing, word assembly, core hand-off
// assumes bit clock, frame clock and data come from one external source
`timescale 1ns/1ps
module serial_audio_in
    import serial_in_pkg::*;
#(
    parameter int WORD_W = serial_in_pkg::WORD_MAX
) (
    input  wire logic                            CORE_CLK_I,
    input  wire logic                            SYS_RST_I,
    input  wire logic                            CTRL_WE_I,
    input  wire logic [serial_in_pkg::MODE_W-1:0] CTRL_MODE_I,
    input  wire logic [serial_in_pkg::WLEN_W-1:0] CTRL_WLEN_I,
    output logic      [serial_in_pkg::MODE_W-1:0] MODE_O,
    output logic      [serial_in_pkg::WLEN_W-1:0] WLEN_O,
    input  wire logic                            BCLK_I,
    input  wire logic                            LRCLK_I,
    input  wire logic                            SDATA_I,
    output logic                                 SAMPLE_VALID_O,
    output logic      [WORD_W-1:0]               LEFT_O,
    output logic      [WORD_W-1:0]               RIGHT_O
);
    import serial_in_pkg::*;

    // core side control register
    logic [MODE_W-1:0] ctrl_mode;
    logic [WLEN_W-1:0] ctrl_wlen;
    logic [MODE_W-1:0] next_ctrl_mode;
    logic [WLEN_W-1:0] next_ctrl_wlen;

    // link side state
    logic                       link_rst;
    logic [MODE_W+WLEN_W-1:0]   ctrl_sync;
    logic [MODE_W-1:0]          mode;
    logic [WLEN_W-1:0]          wlen;
    logic                       r_lr;
    logic                       r_data;
    logic                       f_lr;
    logic                       f_data;
    logic                       prev_lr;
    logic [POS_W-1:0]           pos;
    logic [WORD_W-1:0]          sh;
    logic [WORD_W-1:0]          left_word;
    logic                       cur_right;
    logic                       have;
    logic                       left_ok;
    logic                       next_prev_lr;
    logic [POS_W-1:0]           next_pos;
    logic [WORD_W-1:0]          next_sh;
    logic [WORD_W-1:0]          next_left_word;
    logic                       next_cur_right;
    logic                       next_have;
    logic                       next_left_ok;
    logic                       load;

    // working values of the bit process
    logic                       dsp;
    logic                       lr;
    logic                       bit_in;
    logic                       start;
    logic [POS_W-1:0]           len;
    logic [POS_W-1:0]           lim;
    logic [POS_W-1:0]           offset;
    logic [POS_W-1:0]           k;
    logic [POS_W-1:0]           idx;

    // control register written over the control interface
    always_comb
    begin
        next_ctrl_mode = ctrl_mode;
        next_ctrl_wlen = ctrl_wlen;
        if (CTRL_WE_I)
        begin
            next_ctrl_mode = CTRL_MODE_I;
            next_ctrl_wlen = CTRL_WLEN_I;
        end
        if (SYS_RST_I)
        begin
            next_ctrl_mode = MODE_RESET;
            next_ctrl_wlen = WLEN_RESET;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        ctrl_mode <= next_ctrl_mode;
        ctrl_wlen <= next_ctrl_wlen;
    end

    assign MODE_O = ctrl_mode;
    assign WLEN_O = ctrl_wlen;

    // reset and control levels into the bit clock domain
    level_sync #(.W(1)) u_rst_sync (
        .clk_i (BCLK_I),
        .rst_i (1'b0),
        .d_i   (SYS_RST_I),
        .q_o   (link_rst)
    );

    level_sync #(.W(MODE_W + WLEN_W)) u_ctrl_sync (
        .clk_i (BCLK_I),
        .rst_i (1'b0),
        .d_i   ({ctrl_mode, ctrl_wlen}),
        .q_o   (ctrl_sync)
    );

    assign mode = ctrl_sync[MODE_W+WLEN_W-1:WLEN_W];
    assign wlen = ctrl_sync[WLEN_W-1:0];

    // pin samples on both bit clock edges
    always_ff @(posedge BCLK_I)
    begin
        r_lr   <= LRCLK_I;
        r_data <= SDATA_I;
    end

    always_ff @(negedge BCLK_I)
    begin
        f_lr   <= LRCLK_I;
        f_data <= SDATA_I;
    end

    // framing and word assembly
    always_comb
    begin
        dsp    = (mode == MODE_DSP);
        lr     = dsp ? f_lr : r_lr;
        bit_in = dsp ? f_data : r_data;
        case (wlen)
            WLEN_20: len = LEN_20;
            WLEN_16: len = LEN_16;
            default: len = LEN_24;
        endcase
        lim = (mode == MODE_RJ) ? len : POS_W'(WORD_MAX);
        case (mode)
            MODE_I2S: offset = POS_W'(I2S_DELAY);
            MODE_RJ:  offset = POS_W'(HALF_BCLKS) - len;
            default:  offset = '0;
        endcase
        if (dsp)
        begin
            start = prev_lr & ~lr;
        end
        else
        begin
            start = prev_lr ^ lr;
        end
        next_prev_lr   = lr;
        next_sh        = start ? '0 : sh;
        next_left_word = left_word;
        next_cur_right = cur_right;
        next_have      = have;
        next_left_ok   = left_ok;
        load           = 1'b0;
        if (start)
        begin
            next_pos = '0;
        end
        else if (pos == {POS_W{1'b1}})
        begin
            next_pos = pos;
        end
        else
        begin
            next_pos = pos + 1'b1;
        end
        if (start)
        begin
            if (have && !cur_right)
            begin
                next_left_word = sh;
                next_left_ok   = 1'b1;
            end
            if (have && cur_right && left_ok)
            begin
                load         = 1'b1;
                next_left_ok = 1'b0;
            end
            next_have = 1'b1;
            case (mode)
                MODE_I2S: next_cur_right = lr;
                MODE_DSP: next_cur_right = have ? ~cur_right : 1'b0;
                MODE_RJ:  next_cur_right = ~lr;
                default:  next_cur_right = ~lr;
            endcase
        end
        k   = next_pos - offset;
        idx = POS_W'(WORD_MAX - 1) - k;
        if ((next_pos >= offset) && (k < lim))
        begin
            next_sh[idx[4:0]] = bit_in;
        end
        if (link_rst)
        begin
            next_prev_lr   = 1'b0;
            next_pos       = '0;
            next_sh        = '0;
            next_left_word = '0;
            next_cur_right = 1'b0;
            next_have      = 1'b0;
            next_left_ok   = 1'b0;
            load           = 1'b0;
        end
    end

    always_ff @(posedge BCLK_I)
    begin
        prev_lr   <= next_prev_lr;
        pos       <= next_pos;
        sh        <= next_sh;
        left_word <= next_left_word;
        cur_right <= next_cur_right;
        have      <= next_have;
        left_ok   <= next_left_ok;
    end

    // pair hand-off into the core domain
    pair_crossing #(.W(WORD_W)) u_pair (
        .link_clk_i (BCLK_I),
        .link_rst_i (link_rst),
        .load_i     (load),
        .left_i     (left_word),
        .right_i    (sh),
        .core_clk_i (CORE_CLK_I),
        .core_rst_i (SYS_RST_I),
        .valid_o    (SAMPLE_VALID_O),
        .left_o     (LEFT_O),
        .right_o    (RIGHT_O)
    );
endmodule

// [bench/serial_audio_in_properties.sv]
// pin assertions for the serial audio input port
// assumes binding to serial_audio_in
`timescale 1ns/1ps
module serial_audio_in_properties
    import serial_in_pkg::*;
#(
    parameter int WORD_W = serial_in_pkg::WORD_MAX
) (
    input wire logic              CORE_CLK_I,
    input wire logic              SYS_RST_I,
    input wire logic              CTRL_WE_I,
    input wire logic [MODE_W-1:0] CTRL_MODE_I,
    input wire logic [WLEN_W-1:0] CTRL_WLEN_I,
    input wire logic [MODE_W-1:0] MODE_O,
    input wire logic [WLEN_W-1:0] WLEN_O,
    input wire logic              BCLK_I,
    input wire logic              LRCLK_I,
    input wire logic              SDATA_I,
    input wire logic              SAMPLE_VALID_O,
    input wire logic [WORD_W-1:0] LEFT_O,
    input wire logic [WORD_W-1:0] RIGHT_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    // core cycles since bit clock seen high
    always_comb
    begin
        next_quiet = (quiet == 4'hf) ? quiet : quiet + 4'h1;
        if (BCLK_I)
            next_quiet = 4'h0;
    end
    always_ff @(posedge CORE_CLK_I)
    begin
        quiet <= SYS_RST_I ? 4'hf : next_quiet;
    end
    property p_pulse;
        SAMPLE_VALID_O |=> !SAMPLE_VALID_O;
    endproperty
    a_pulse: assert property (p_pulse) else $error("valid too long");
    property p_take;
        CTRL_WE_I |=> MODE_O == $past(CTRL_MODE_I) && WLEN_O == $past(CTRL_WLEN_I);
    endproperty
    a_take: assert property (p_take) else $error("control not taken");
    property p_hold;
        $changed(MODE_O) || $changed(WLEN_O) |-> $past(CTRL_WE_I);
    endproperty
    a_hold: assert property (p_hold) else $error("control moved");
    property p_reset;
        $fell(SYS_RST_I) |-> MODE_O == MODE_RESET && WLEN_O == WLEN_RESET
            && LEFT_O == '0 && RIGHT_O == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("bad reset value");
    property p_start;
        $fell(SYS_RST_I) |-> !SAMPLE_VALID_O [*3];
    endproperty
    a_start: assert property (p_start) else $error("early valid");
    property p_data;
        $changed(LEFT_O) || $changed(RIGHT_O) |-> SAMPLE_VALID_O;
    endproperty
    a_data: assert property (p_data) else $error("data moved");
    property p_link;
        SAMPLE_VALID_O |-> quiet < 4'h8;
    endproperty
    a_link: assert property (p_link) else $error("valid without link");
    property p_wlen;
        CTRL_WE_I ##1 !CTRL_WE_I |=> WLEN_O == $past(CTRL_WLEN_I, 2);
    endproperty
    a_wlen: assert property (p_wlen) else $error("length lost");
endmodule

bind serial_audio_in serial_audio_in_properties #(.WORD_W(WORD_W)) chk_i (.*);

// [bench/audio_source_model.sv]
// behavioural audio source: bit clock, frame clock, data
// assumes callers run idle and frame one at a time
`timescale 1ns/1ps
module audio_source_model
    import serial_in_pkg::*;
(
    output logic bclk_o,
    output logic lrclk_o,
    output logic sdata_o
);
    initial
    begin
        bclk_o = 1'b0;
        lrclk_o = 1'b0;
        sdata_o = 1'b0;
    end
    // one 48 ns bit, data steady at both edges
    task automatic slot(input logic lr, input logic d);
    begin
        lrclk_o = lr;
        sdata_o = d;
        #12 bclk_o = 1'b1;
        #24 bclk_o = 1'b0;
        #12;
    end
    endtask
    // clock burst, data line toggling
    task automatic idle(input int n, input logic lr);
    begin
        repeat (n) slot(lr, ~sdata_o);
    end
    endtask
    // 64 bit clocks, left word then right
    task automatic frame(input logic [1:0] m, input int n, input logic [23:0] l,
                         input logic [23:0] r);
        int   off;
        int   j;
        logic lr;
    begin
        off = (m == MODE_RJ) ? 32 - n : int'(m != MODE_LJ);
        for (int c = 0; c < 2; c++)
        begin
            for (int k = 0; k < HALF_BCLKS; k++)
            begin
                j = k - off;
                lr = (m == MODE_I2S) == c[0];
                if (m == MODE_DSP)
                    lr = (k == 0);
                if (j >= 0 && j < n && j < 24)
                    slot(lr, (c == 0) ? l[23 - j] : r[23 - j]);
                else if (j >= n)
                    slot(lr, 1'b0); // short word padded with zeros
                else
                    slot(lr, ~sdata_o);
            end
        end
    end
    endtask
endmodule

// [bench/serial_audio_in_tb.sv]
// self-checking bench for the serial audio input port
// assumes audio_source_model drives the link pins
`timescale 1ns/1ps
module serial_audio_in_tb;
    import serial_in_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        we = 1'b0;
    logic [1:0]  m_in = 2'h0;
    logic [1:0]  w_in = 2'h0;
    logic [1:0]  m_out;
    logic [1:0]  w_out;
    logic        bclk;
    logic        lrclk;
    logic        sdata;
    logic        vld;
    logic [23:0] lo;
    logic [23:0] ro;
    logic [47:0] q[$];
    int          fail_count = 0;
    int          num_checks = 0;
    always #20 clk = ~clk;
    serial_audio_in DUT (.CORE_CLK_I(clk), .SYS_RST_I(rst), .CTRL_WE_I(we),
        .CTRL_MODE_I(m_in), .CTRL_WLEN_I(w_in), .MODE_O(m_out), .WLEN_O(w_out),
        .BCLK_I(bclk), .LRCLK_I(lrclk), .SDATA_I(sdata), .SAMPLE_VALID_O(vld),
        .LEFT_O(lo), .RIGHT_O(ro));
    audio_source_model src (.bclk_o(bclk), .lrclk_o(lrclk), .sdata_o(sdata));
    always @(posedge clk)
    begin
        if (vld === 1'b1)
            q.push_back({lo, ro});
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    begin
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task automatic end_sim;
    begin
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task automatic do_rst(input logic lv);
    begin
        @(posedge clk);
        rst <= 1'b1;
        fork
            src.idle(16, lv);
            repeat (16) @(posedge clk);
        join
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    end
    endtask
    // reset, set mode, two pairs plus a closing frame
    task automatic run(input logic [1:0] m, input logic [1:0] wc, input int n,
                       input logic [23:0] d[4]);
        logic [23:0] k;
    begin
        k = ~(24'hffffff >> n);
        do_rst(m == MODE_I2S);
        q.delete();
        we <= 1'b1;
        m_in <= m;
        w_in <= wc;
        @(posedge clk);
        we <= 1'b0;
        src.idle(8, m == MODE_I2S);
        src.frame(m, n, d[0], d[1]);
        src.frame(m, n, d[2], d[3]);
        src.frame(m, n, 24'h0, 24'h0);
        chk(48'(q.size()), 48'h2);
        chk(q[0], {d[0] & k, d[1] & k});
        chk(q[1], {d[2] & k, d[3] & k});
    end
    endtask
    task automatic t_reset;
    begin
        do_rst(1'b0);
        chk({44'h0, m_out, w_out}, {44'h0, MODE_RESET, WLEN_RESET});
    end
    endtask
    task automatic t_ctrl;
    begin
        for (int i = 0; i < 5; i++)
        begin
            we <= (i < 4);
            m_in <= i[1:0];
            w_in <= 2'(i % 3);
            @(posedge clk);
            if (i > 0)
                chk({44'h0, m_out, w_out}, {44'h0, 2'(i - 1), 2'((i - 1) % 3)});
        end
    end
    endtask
    task automatic t_lj;
    begin
        run(MODE_LJ, WLEN_24, 24, '{24'h800001, 24'h7ffffe, 24'ha5c30f, 24'h5a3cf0});
        run(MODE_LJ, WLEN_16, 32, '{24'hc0ffee, 24'h13579b, 24'hfedcba, 24'h000001});
    end
    endtask
    task automatic t_i2s;
    begin
        run(MODE_I2S, WLEN_24, 24, '{24'h81a5c3, 24'h7e5a3c, 24'hfffffe, 24'h000001});
    end
    endtask
    task automatic t_rj;
    begin
        for (int i = 0; i < 3; i++)
            run(MODE_RJ, 2'(i), 24 - 4 * i, '{24'hf0f0f1, 24'h8ccc3f, 24'h123457, 24'hedcba9});
    end
    endtask
    task automatic t_dsp;
    begin
        run(MODE_DSP, WLEN_24, 20, '{24'h9a5a5f, 24'h65a5a1, 24'h80000f, 24'h7ffff0});
    end
    endtask
    initial
    begin
        t_reset();
        t_ctrl();
        t_lj();
        t_i2s();
        t_rj();
        t_dsp();
        end_sim();
    end
    initial
    begin
        #1000000;
        fail_count++;
        end_sim();
    end
endmodule
